// ### core/jtlc_tx_link.sv
`timescale 1ns/1ns
`default_nettype none
module jtlc_fifo #(
	parameter int W = 12,
	parameter int D = 8
) (
	input  wire logic         ref_clk,
	input  wire logic         rst_n,
	input  wire logic         in_valid,
	input  wire logic [W-1:0] in_data,
	output logic              in_ready,
	output logic              out_valid,
	output logic [W-1:0]      out_data,
	input  wire logic         out_ready
);
	localparam int PW = $clog2(D);
	localparam int CW = $clog2(D + 1);
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [PW-1:0]       wp;
		logic [PW-1:0]       rp;
		logic [CW-1:0]       cnt;
	} jtlc_fifo_t;
	jtlc_fifo_t q, n;
	logic push, pop;

	assign in_ready  = q.cnt != CW'(D);
	assign out_valid = q.cnt != '0;
	assign out_data  = q.mem[q.rp];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb begin
		n = q;
		if (push) begin
			n.mem[q.wp] = in_data;
			n.wp = (q.wp == PW'(D - 1)) ? '0 : q.wp + 1'b1;
		end
		if (pop)
			n.rp = (q.rp == PW'(D - 1)) ? '0 : q.rp + 1'b1;
		if (push && !pop)
			n.cnt = q.cnt + 1'b1;
		else if (pop && !push)
			n.cnt = q.cnt - 1'b1;
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			q.wp  <= '0;
			q.rp  <= '0;
			q.cnt <= '0;
			q.mem <= '0;
		end else begin
			q <= n;
		end
	end
endmodule

// Behaviour
// - Normal mapping uses lanes zero to L-1
// - Upper option uses lanes four to 4+L-1
// - Host uses upper option only with L<=4
// - Sync source: pin, timestamp pins, software
// - Timestamp source needs timestamp receiver enabled
// - Format bit: offset binary or two's complement
// - 8B/10B scrambling follows scramble-enable bit
// - 64B/66B always scrambles, bit ignored
// - Host should keep 8B/10B scrambling on; host writes cfg_scramble as given
// - Host changes control only while link disabled
// - Host writes reserved bits as zero
// - Test select zero means normal data
// - Codes 7,8,9,16: K28.5, ILA, RPAT, K28.7
// - Codes 10,11 hold outputs low, high
// - Code 15 sends clock word 0x00FF
// - Host uses 8B/10B-only patterns in 8B/10B
// - Disabled link: reset, lanes off, counters held at zero
// - Software sync bit low requests synchronisation
// - Output mode sets lane count and encoding
module jtlc_tx_link
	import jtlc_pkg::*;
(
	input  wire logic                          ref_clk,
	input  wire logic                          rst_n,
	jtlc_link_if.dev                           link,
	input  wire logic                          sample_valid,
	input  wire logic [jtlc_pkg::SAMPLE_W-1:0] sample_data,
	output logic                               sample_ready,
	output logic                               link_up
);
	import jtlc_pkg::*;

	typedef enum logic [1:0] {S_OFF, S_CGS, S_DATA} jtlc_dev_state_t;
	typedef struct packed {
		logic [7:0]      enable;
		logic [7:0]      mode;
		logic [7:0]      sync_sw;
		logic [7:0]      ctrl;
		logic [7:0]      test;
		logic [7:0]      ts_rx;
		logic [2:0]      se_sync;
		logic [2:0]      ts_sync;
		logic            se_lvl;
		logic            ts_lvl;
		jtlc_dev_state_t st;
		logic [30:0]     prbs;
		logic [14:0]     scramble_enable;
		logic [7:0]      cnt;
		logic [4:0]      mf;
		logic [7:0]      rdata;
		logic [63:0]     ldata;
		logic [7:0]      lk;
		logic [7:0]      lon;
		logic            hold_lo;
		logic            hold_hi;
	} jtlc_dev_t;

	jtlc_dev_t q, n;
	logic                fifo_valid;
	logic [SAMPLE_W-1:0] fifo_data;
	logic                fifo_ready;
	logic [3:0]          lane_cnt;
	logic [3:0]          lane_base;
	logic [LANES-1:0]    lane_act;
	logic                en;
	logic                mode64;
	logic                sync_n;
	logic [1:0]          sync_sel;
	logic [4:0]          tsel;

	function automatic logic [30:0] prbs_step(input logic [30:0] s, input logic [4:0] t);
		logic fb;
		fb = 1'b0;
		for (int b = 0; b < 16; b++) begin
			case (t)
				TP_PRBS7:  fb = s[6] ^ s[5];
				TP_PRBS9:  fb = s[8] ^ s[4];
				TP_PRBS15: fb = s[14] ^ s[13];
				TP_PRBS23: fb = s[22] ^ s[17];
				default:   fb = s[30] ^ s[27];
			endcase
			s = {s[29:0], fb};
		end
		return s;
	endfunction

	// Self-synchronising 1+x^14+x^15, msb first
	function automatic logic [30:0] scramble(input logic [14:0] s, input logic [15:0] d);
		logic o;
		o = 1'b0;
		for (int b = 15; b >= 0; b--) begin
			o = d[b] ^ s[14] ^ s[13];
			s = {s[13:0], o};
			d[b] = o;
		end
		return {s, d};
	endfunction

	function automatic logic [7:0] rpat(input logic [7:0] i);
		case (i[3:0])
			4'h0: return 8'hbe;
			4'h1: return 8'hd7;
			4'h2: return 8'h23;
			4'h3: return 8'h47;
			4'h4: return 8'h6b;
			4'h5: return 8'h8f;
			4'h6: return 8'hb3;
			4'h7: return 8'h14;
			4'h8: return 8'h5e;
			4'h9: return 8'hfb;
			4'ha: return 8'h35;
			default: return 8'h59;
		endcase
	endfunction

	jtlc_fifo #(.W(SAMPLE_W), .D(FIFO_DEPTH)) u_fifo (
		.ref_clk   (ref_clk),
		.rst_n     (rst_n),
		.in_valid  (sample_valid),
		.in_data   (sample_data),
		.in_ready  (sample_ready),
		.out_valid (fifo_valid),
		.out_data  (fifo_data),
		.out_ready (fifo_ready)
	);

	assign en       = q.enable[0];
	assign mode64   = q.mode[MODE_64B_BIT];
	assign lane_cnt = 4'h1 << q.mode[1:0];
	assign lane_base = q.ctrl[CTRL_UPPER_BIT] ? 4'h4 : 4'h0;
	assign sync_sel = q.ctrl[CTRL_SYNC_LSB +: 2];
	assign tsel     = q.test[4:0];
	// Samples wait in the FIFO while no normal data is sent
	assign fifo_ready = en && (q.st == S_DATA) && (tsel == TP_OFF);

	generate
		for (genvar i = 0; i < LANES; i++) begin : g_lane
			assign lane_act[i] = en && (4'(i) >= lane_base)
				&& (4'(i) < lane_base + lane_cnt);
		end
	endgenerate

	always_comb begin
		case (sync_sel)
			SYNC_SEL_SE: sync_n = q.se_lvl;
			SYNC_SEL_TS: sync_n = q.ts_lvl;
			default:     sync_n = 1'b1;
		endcase
		sync_n = sync_n & q.sync_sw[0];
	end

	always_comb begin
		logic [15:0] w;
		logic        k;
		logic [30:0] sr;
		w  = 16'h0000;
		k  = 1'b0;
		sr = 31'h0;
		n = q;
		if (link.reg_wr) begin
			if (link.reg_addr == ADDR_ENABLE)
				n.enable = link.reg_wdata & MASK_ENABLE;
			else if (link.reg_addr == ADDR_MODE)
				n.mode = link.reg_wdata & MASK_MODE;
			else if (link.reg_addr == ADDR_SYNC_SW)
				n.sync_sw = link.reg_wdata & MASK_SYNC_SW;
			else if (link.reg_addr == ADDR_CTRL)
				n.ctrl = link.reg_wdata & MASK_CTRL;
			else if (link.reg_addr == ADDR_TEST)
				n.test = link.reg_wdata & MASK_TEST;
			else if (link.reg_addr == ADDR_TS_RX)
				n.ts_rx = link.reg_wdata & MASK_TS_RX;
		end
		n.rdata = 8'h00;
		if (link.reg_rd) begin
			if (link.reg_addr == ADDR_ENABLE)
				n.rdata = q.enable;
			else if (link.reg_addr == ADDR_MODE)
				n.rdata = q.mode;
			else if (link.reg_addr == ADDR_SYNC_SW)
				n.rdata = q.sync_sw;
			else if (link.reg_addr == ADDR_CTRL)
				n.rdata = q.ctrl;
			else if (link.reg_addr == ADDR_TEST)
				n.rdata = q.test;
			else if (link.reg_addr == ADDR_TS_RX)
				n.rdata = q.ts_rx;
			else if (link.reg_addr == ADDR_STATUS) begin
				n.rdata[STAT_SYNC_BIT] = sync_n;
				n.rdata[STAT_UP_BIT]   = link_up;
			end
		end
		// Timestamp input is not received unless its receiver is on
		n.se_sync = {q.se_sync[1:0], link.single_ended_sync_pin};
		n.ts_sync = {q.ts_sync[1:0], link.differential_timestamp_pins | ~q.ts_rx[0]};
		if (q.se_sync[1] == q.se_sync[2])
			n.se_lvl = q.se_sync[2];
		if (q.ts_sync[1] == q.ts_sync[2])
			n.ts_lvl = q.ts_sync[2];

		n.hold_lo = 1'b0;
		n.hold_hi = 1'b0;
		n.cnt = q.cnt + 8'h01;
		case (q.st)
			S_OFF:   n.st = en ? S_CGS : S_OFF;
			default: n.st = sync_n ? S_DATA : S_CGS;
		endcase
		if (tsel == TP_PRBS7 || tsel == TP_PRBS15 || tsel == TP_PRBS23
			|| tsel == TP_PRBS9 || tsel == TP_PRBS31)
			n.prbs = prbs_step(q.prbs, tsel);
		else
			n.prbs = '1;
		case (tsel)
			TP_OFF: begin
				if (q.st == S_CGS) begin
					w = {CH_K28_5, CH_K28_5};
					k = 1'b1;
				end else if (fifo_valid && fifo_ready) begin
					w = {4'h0, q.ctrl[CTRL_FMT_BIT] ? fifo_data
						: {~fifo_data[SAMPLE_W-1], fifo_data[SAMPLE_W-2:0]}};
					if (mode64 || q.ctrl[CTRL_SCR_BIT]) begin
						sr = scramble(q.scramble_enable, w);
						n.scramble_enable = sr[30:16];
						w = sr[15:0];
					end
				end
			end
			TP_PRBS7, TP_PRBS15, TP_PRBS23, TP_PRBS9, TP_PRBS31:
				w = q.prbs[15:0];
			TP_RAMP: begin
				w = {q.cnt + 8'h01, q.cnt};
				n.cnt = q.cnt + 8'h02;
			end
			TP_TRANS: w = {~q.cnt, q.cnt};
			TP_D21_5: w = {CH_D21_5, CH_D21_5};
			TP_K28_5: begin
				w = {CH_K28_5, CH_K28_5};
				k = 1'b1;
			end
			TP_ILA: begin
				k = (q.cnt[1:0] == 2'h0) || (q.cnt[1:0] == 2'h3);
				w = (q.cnt[1:0] == 2'h0) ? {CH_K28_0, CH_K28_0}
					: (q.cnt[1:0] == 2'h3) ? {CH_K28_3, CH_K28_3} : {q.cnt, q.cnt};
			end
			TP_RPAT: begin
				w = {rpat(q.cnt), rpat(q.cnt)};
				n.cnt = (q.cnt >= RPAT_LAST) ? 8'h00 : q.cnt + 8'h01;
			end
			TP_LOW:   n.hold_lo = 1'b1;
			TP_HIGH:  n.hold_hi = 1'b1;
			TP_CLOCK: w = CLOCK_WORD;
			TP_K28_7: begin
				w = {CH_K28_7, CH_K28_7};
				k = 1'b1;
			end
			default: w = 16'h0000;
		endcase
		n.mf = q.mf + 5'h01;
		n.lon = lane_act;
		for (int i = 0; i < LANES; i++) begin
			n.ldata[i*8 +: 8] = lane_act[i] ? (i[0] ? w[15:8] : w[7:0]) : 8'h00;
			n.lk[i] = lane_act[i] & k;
		end
		if (!en) begin
			n.st = S_OFF;
			n.mf = 5'h00;
			n.cnt = 8'h00;
			n.scramble_enable = '1;
			n.prbs = '1;
			n.ldata = '0;
			n.lk = '0;
			n.lon = '0;
			n.hold_lo = 1'b0;
			n.hold_hi = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			q <= '0;
			q.enable  <= RST_ENABLE;
			q.mode    <= RST_MODE;
			q.sync_sw <= RST_SYNC_SW;
			q.ctrl    <= RST_CTRL;
			q.test    <= RST_TEST;
			q.ts_rx   <= RST_TS_RX;
			q.se_sync <= '1;
			q.ts_sync <= '1;
			q.se_lvl  <= 1'b1;
			q.ts_lvl  <= 1'b1;
			q.st      <= S_OFF;
			q.prbs    <= '1;
			q.scramble_enable     <= '1;
		end else begin
			q <= n;
		end
	end

	assign link_up             = en && (q.st == S_DATA);
	assign link.reg_rdata      = q.rdata;
	assign link.lane_data      = q.ldata;
	assign link.lane_k         = q.lk;
	assign link.lane_on        = q.lon;
	assign link.lane_hold_low  = q.hold_lo;
	assign link.lane_hold_high = q.hold_hi;
endmodule
`default_nettype wire

// ### shared/jtlc_pkg.sv
package jtlc_pkg;

	localparam int ADDR_W     = 12;
	localparam int DATA_W     = 8;
	localparam int LANES      = 8;
	localparam int SAMPLE_W   = 12;
	localparam int FIFO_DEPTH = 8;

	// Register map
	localparam logic [11:0] ADDR_ENABLE  = 12'h200;
	localparam logic [11:0] ADDR_MODE    = 12'h201;
	localparam logic [11:0] ADDR_SYNC_SW = 12'h203;
	localparam logic [11:0] ADDR_CTRL    = 12'h204;
	localparam logic [11:0] ADDR_TEST    = 12'h205;
	localparam logic [11:0] ADDR_STATUS  = 12'h208;
	localparam logic [11:0] ADDR_TS_RX   = 12'h20a;

	// Reset values
	localparam logic [7:0] RST_ENABLE  = 8'h01;
	localparam logic [7:0] RST_MODE    = 8'h00;
	localparam logic [7:0] RST_SYNC_SW = 8'h01;
	localparam logic [7:0] RST_CTRL    = 8'h03;
	localparam logic [7:0] RST_TEST    = 8'h00;
	localparam logic [7:0] RST_TS_RX   = 8'h00;

	// Writable field masks; everything else is reserved and reads zero
	localparam logic [7:0] MASK_ENABLE  = 8'h01;
	localparam logic [7:0] MASK_MODE    = 8'h3f;
	localparam logic [7:0] MASK_SYNC_SW = 8'h01;
	localparam logic [7:0] MASK_CTRL    = 8'h1f;
	localparam logic [7:0] MASK_TEST    = 8'h1f;
	localparam logic [7:0] MASK_TS_RX   = 8'h01;

	// Field positions
	localparam int CTRL_SCR_BIT   = 0;
	localparam int CTRL_FMT_BIT   = 1;
	localparam int CTRL_SYNC_LSB  = 2;
	localparam int CTRL_UPPER_BIT = 4;
	localparam int MODE_64B_BIT   = 5;
	localparam int STAT_SYNC_BIT  = 5;
	localparam int STAT_UP_BIT    = 6;

	// Sync source codes
	localparam logic [1:0] SYNC_SEL_SE = 2'h0;
	localparam logic [1:0] SYNC_SEL_TS = 2'h1;
	localparam logic [1:0] SYNC_SEL_SW = 2'h2;

	// Test-select codes
	localparam logic [4:0] TP_OFF    = 5'h00;
	localparam logic [4:0] TP_PRBS7  = 5'h01;
	localparam logic [4:0] TP_PRBS15 = 5'h02;
	localparam logic [4:0] TP_PRBS23 = 5'h03;
	localparam logic [4:0] TP_RAMP   = 5'h04;
	localparam logic [4:0] TP_TRANS  = 5'h05;
	localparam logic [4:0] TP_D21_5  = 5'h06;
	localparam logic [4:0] TP_K28_5  = 5'h07;
	localparam logic [4:0] TP_ILA    = 5'h08;
	localparam logic [4:0] TP_RPAT   = 5'h09;
	localparam logic [4:0] TP_LOW    = 5'h0a;
	localparam logic [4:0] TP_HIGH   = 5'h0b;
	localparam logic [4:0] TP_RSVD   = 5'h0c;
	localparam logic [4:0] TP_PRBS9  = 5'h0d;
	localparam logic [4:0] TP_PRBS31 = 5'h0e;
	localparam logic [4:0] TP_CLOCK  = 5'h0f;
	localparam logic [4:0] TP_K28_7  = 5'h10;

	// Characters
	localparam logic [7:0] CH_K28_0 = 8'h1c;
	localparam logic [7:0] CH_K28_3 = 8'h7c;
	localparam logic [7:0] CH_K28_5 = 8'hbc;
	localparam logic [7:0] CH_K28_7 = 8'hfc;
	localparam logic [7:0] CH_D21_5 = 8'hb5;
	localparam logic [15:0] CLOCK_WORD = 16'h00ff;
	localparam logic [7:0] RPAT_LAST = 8'h0b;

endpackage

// ### shared/jtlc_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface jtlc_link_if;
	logic        reg_wr;
	logic        reg_rd;
	logic [11:0] reg_addr;
	logic [7:0]  reg_wdata;
	logic [7:0]  reg_rdata;
	logic        single_ended_sync_pin;
	logic        differential_timestamp_pins;
	logic [63:0] lane_data;
	logic [7:0]  lane_k;
	logic [7:0]  lane_on;
	logic        lane_hold_low;
	logic        lane_hold_high;

	modport dev (
		input  reg_wr, reg_rd, reg_addr, reg_wdata,
		input  single_ended_sync_pin, differential_timestamp_pins,
		output reg_rdata, lane_data, lane_k, lane_on, lane_hold_low, lane_hold_high
	);
	modport host (
		output reg_wr, reg_rd, reg_addr, reg_wdata,
		output single_ended_sync_pin, differential_timestamp_pins,
		input  reg_rdata, lane_data, lane_k, lane_on, lane_hold_low, lane_hold_high
	);
endinterface
`default_nettype wire

// ### core/jtlc_link_host.sv
`timescale 1ns/1ns
`default_nettype none
module jtlc_link_host
	import jtlc_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	jtlc_link_if.host       link,
	input  wire logic       cfg_start,
	input  wire logic [5:0] cfg_mode,
	input  wire logic [4:0] cfg_test,
	input  wire logic [1:0] cfg_sync_sel,
	input  wire logic       cfg_upper,
	input  wire logic       cfg_format,
	input  wire logic       cfg_scramble,
	input  wire logic       rx_sync_request,
	output logic            cfg_busy,
	output logic            cfg_done,
	output logic [7:0]      status
);
	import jtlc_pkg::*;

	typedef enum logic [3:0] {
		H_IDLE, H_DIS, H_MODE, H_CTRL, H_TEST, H_TSRX, H_SYNC, H_EN, H_RD, H_WAIT, H_CAP
	} jtlc_host_state_t;
	typedef struct packed {
		jtlc_host_state_t st;
		logic [5:0]       mode;
		logic [4:0]       test;
		logic [1:0]       sync_sel;
		logic             upper;
		logic             fmt;
		logic             scramble_enable;
		logic             wr;
		logic             rd;
		logic [11:0]      addr;
		logic [7:0]       wdata;
		logic             sync_out_n;
		logic             done;
		logic [7:0]       status;
	} jtlc_host_t;

	jtlc_host_t q, n;
	logic       bad_test;

	// 8B/10B-only patterns, and reserved codes
	assign bad_test = (cfg_test == TP_RSVD) || (cfg_test > TP_K28_7)
		|| (cfg_mode[MODE_64B_BIT] && (cfg_test == TP_K28_5 || cfg_test == TP_ILA
		|| cfg_test == TP_RPAT || cfg_test == TP_K28_7));

	always_comb begin
		n = q;
		n.wr = 1'b0;
		n.rd = 1'b0;
		n.done = 1'b0;
		n.sync_out_n = ~rx_sync_request;
		case (q.st)
			H_IDLE: begin
				if (cfg_start) begin
					n.st = H_DIS;
					n.mode = cfg_mode;
					n.test = bad_test ? TP_OFF : cfg_test;
					n.sync_sel = cfg_sync_sel;
					n.upper = cfg_upper && (cfg_mode[1:0] <= 2'h2);
					n.fmt = cfg_format;
					n.scramble_enable = cfg_scramble;
				end
			end
			H_DIS: begin
				n.wr = 1'b1;
				n.addr = ADDR_ENABLE;
				n.wdata = 8'h00;
				n.st = H_MODE;
			end
			H_MODE: begin
				n.wr = 1'b1;
				n.addr = ADDR_MODE;
				n.wdata = {2'h0, q.mode};
				n.st = H_CTRL;
			end
			H_CTRL: begin
				n.wr = 1'b1;
				n.addr = ADDR_CTRL;
				n.wdata = {3'h0, q.upper, q.sync_sel, q.fmt, q.scramble_enable};
				n.st = H_TEST;
			end
			H_TEST: begin
				n.wr = 1'b1;
				n.addr = ADDR_TEST;
				n.wdata = {3'h0, q.test};
				n.st = H_TSRX;
			end
			H_TSRX: begin
				n.wr = 1'b1;
				n.addr = ADDR_TS_RX;
				n.wdata = {7'h00, q.sync_sel == SYNC_SEL_TS};
				n.st = H_SYNC;
			end
			H_SYNC: begin
				n.wr = 1'b1;
				n.addr = ADDR_SYNC_SW;
				n.wdata = RST_SYNC_SW;
				n.st = H_EN;
			end
			H_EN: begin
				n.wr = 1'b1;
				n.addr = ADDR_ENABLE;
				n.wdata = MASK_ENABLE;
				n.st = H_RD;
			end
			H_RD: begin
				n.rd = 1'b1;
				n.addr = ADDR_STATUS;
				n.st = H_WAIT;
			end
			H_WAIT: n.st = H_CAP;
			default: begin
				n.status = link.reg_rdata;
				n.done = 1'b1;
				n.st = H_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			q <= '0;
			q.st <= H_IDLE;
			q.sync_out_n <= 1'b1;
		end else begin
			q <= n;
		end
	end

	assign link.reg_wr    = q.wr;
	assign link.reg_rd    = q.rd;
	assign link.reg_addr  = q.addr;
	assign link.reg_wdata = q.wdata;
	assign link.single_ended_sync_pin       = q.sync_out_n;
	assign link.differential_timestamp_pins = q.sync_out_n;
	assign cfg_busy = q.st != H_IDLE;
	assign cfg_done = q.done;
	assign status   = q.status;
endmodule
`default_nettype wire

// ### sim/jtlc_props.sv
`timescale 1ns/1ns
`default_nettype none
module jtlc_props
	import jtlc_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [11:0] reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic [7:0]  reg_rdata,
	input  wire logic        single_ended_sync_pin,
	input  wire logic        differential_timestamp_pins,
	input  wire logic [63:0] lane_data,
	input  wire logic [7:0]  lane_k,
	input  wire logic [7:0]  lane_on,
	input  wire logic        lane_hold_low,
	input  wire logic        lane_hold_high
);
	typedef struct packed {
		logic       en;
		logic [5:0] mode;
		logic [4:0] ctrl;
		logic [4:0] test;
	} jtlc_shadow_t;
	jtlc_shadow_t sh;
	jtlc_shadow_t next_sh;
	logic [7:0]   exp_on;
	logic         quiet;
	// Shadow of written fields; trusts the host to write only legal values
	always_comb begin
		next_sh = sh;
		if (reg_wr && reg_addr == ADDR_ENABLE) next_sh.en = reg_wdata[0];
		if (reg_wr && reg_addr == ADDR_MODE) next_sh.mode = reg_wdata[5:0];
		if (reg_wr && reg_addr == ADDR_CTRL) next_sh.ctrl = reg_wdata[4:0];
		if (reg_wr && reg_addr == ADDR_TEST) next_sh.test = reg_wdata[4:0];
		if (!rst_n) next_sh = {RST_ENABLE[0], RST_MODE[5:0], RST_CTRL[4:0], RST_TEST[4:0]};
	end
	always_ff @(posedge ref_clk) begin
		sh <= next_sh;
	end
	assign exp_on = 8'((9'h001 << (4'h1 << sh.mode[1:0])) - 9'h001) << (sh.ctrl[4] ? 4 : 0);
	// Lane 0 only is judged, so the upper mapping is left out here
	assign quiet = sh.en && sh.ctrl[3:2] == SYNC_SEL_SE && single_ended_sync_pin && !sh.ctrl[4];
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	lower_lane_map_a: assert property (
		sh.en && lane_on != 8'h00 && !sh.ctrl[4] |-> lane_on == exp_on)
		else $error("lower lane map wrong");
	upper_lane_map_a: assert property (
		sh.en && lane_on != 8'h00 && sh.ctrl[4] |-> lane_on == exp_on && lane_on[3:0] == 4'h0)
		else $error("upper lane map wrong");
	disable_lanes_off_a: assert property (
		reg_wr && reg_addr == ADDR_ENABLE && !reg_wdata[0] |-> ##[1:4] lane_on == 8'h00)
		else $error("lanes still on after disable");
	sync_char_a: assert property (
		(sh.en && sh.ctrl[3:2] == SYNC_SEL_SE && !sh.ctrl[4] && !single_ended_sync_pin)[*8]
		|-> lane_data[7:0] == CH_K28_5 && lane_k[0]) else $error("no K28.5 under sync");
	hold_low_cause_a: assert property (
		lane_hold_low |-> sh.test == TP_LOW || $past(sh.test) == TP_LOW)
		else $error("hold low without its code");
	hold_high_a: assert property (
		(quiet && sh.test == TP_HIGH)[*8] |-> lane_hold_high && !lane_hold_low)
		else $error("hold high missing");
	clock_word_a: assert property (
		(quiet && sh.test == TP_CLOCK)[*8] |-> lane_data[7:0] == CLOCK_WORD[7:0] && !lane_k[0])
		else $error("clock word wrong");
	k28_7_char_a: assert property (
		(quiet && sh.test == TP_K28_7)[*8] |-> lane_data[7:0] == CH_K28_7 && lane_k[0])
		else $error("K28.7 wrong");
	d21_5_char_a: assert property (
		(quiet && sh.test == TP_D21_5)[*8] |-> lane_data[7:0] == CH_D21_5 && !lane_k[0])
		else $error("D21.5 wrong");
endmodule
`default_nettype wire

// ### sim/jtlc_link_control_test_bench.sv
`timescale 1ns/1ns
`default_nettype none
module jtlc_link_control_test_bench;
	import jtlc_pkg::*;
	logic        ref_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        cfg_start = 1'b0;
	logic [5:0]  cfg_mode = 6'h00;
	logic [4:0]  cfg_test = 5'h00;
	logic [1:0]  cfg_sync_sel = 2'h0;
	logic        cfg_upper = 1'b0;
	logic        cfg_format = 1'b1;
	logic        cfg_scramble = 1'b1;
	logic        rx_sync_request = 1'b0;
	logic        sample_valid = 1'b0;
	logic [11:0] sample_data = 12'h000;
	logic        cfg_busy, cfg_done, sample_ready, link_up;
	logic [7:0]  status;
	int          error_cnt = 0;
	int          checked = 0;
	int          cycles = 0;
	jtlc_link_if link ();
	jtlc_tx_link u_jtlc_tx_link (.ref_clk(ref_clk), .rst_n(rst_n), .link(link),
		.sample_valid(sample_valid), .sample_data(sample_data),
		.sample_ready(sample_ready), .link_up(link_up));
	jtlc_link_host u_jtlc_link_host (.ref_clk(ref_clk), .rst_n(rst_n), .link(link),
		.cfg_start(cfg_start), .cfg_mode(cfg_mode), .cfg_test(cfg_test),
		.cfg_sync_sel(cfg_sync_sel), .cfg_upper(cfg_upper), .cfg_format(cfg_format),
		.cfg_scramble(cfg_scramble), .rx_sync_request(rx_sync_request),
		.cfg_busy(cfg_busy), .cfg_done(cfg_done), .status(status));
	jtlc_props u_jtlc_props (.ref_clk(ref_clk), .rst_n(rst_n), .reg_wr(link.reg_wr),
		.reg_rd(link.reg_rd), .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata),
		.reg_rdata(link.reg_rdata), .single_ended_sync_pin(link.single_ended_sync_pin),
		.differential_timestamp_pins(link.differential_timestamp_pins),
		.lane_data(link.lane_data), .lane_k(link.lane_k), .lane_on(link.lane_on),
		.lane_hold_low(link.lane_hold_low), .lane_hold_high(link.lane_hold_high));
	initial begin
		forever #10 ref_clk = ~ref_clk;
	end
	task automatic complete_run;
		$display("Checks %0d, mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// Ceiling well above the roughly 1000 cycles the sequence needs
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			$display("Error at %0t: run hung", $time);
			complete_run();
		end
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic configure(input logic [5:0] m, input logic [4:0] t, input logic [1:0] s,
		input logic u, input logic f, input logic sc);
		int n;
		@(posedge ref_clk);
		{cfg_mode, cfg_test, cfg_sync_sel, cfg_upper, cfg_format, cfg_scramble} <= {m, t, s, u, f, sc};
		cfg_start <= 1'b1;
		@(posedge ref_clk);
		cfg_start <= 1'b0;
		for (n = 0; n < 40 && cfg_done !== 1'b1; n++) @(negedge ref_clk);
		check(16'(n < 40), 16'h0001);
		check(16'({cfg_busy, status[STAT_SYNC_BIT]}), 16'h0001);
		repeat (12) @(posedge ref_clk);
	endtask
	// Streams four copies of one sample and watches lanes 0 and 1 for a word
	task automatic look(input logic [15:0] w, output logic hit);
		hit = 1'b0;
		@(posedge ref_clk);
		sample_valid <= 1'b1;
		sample_data <= 12'h123;
		repeat (4) @(posedge ref_clk);
		sample_valid <= 1'b0;
		for (int i = 0; i < 12; i++) begin
			@(negedge ref_clk);
			if (link.lane_data[15:0] === w) hit = 1'b1;
		end
	endtask
	task automatic lane_map_test;
		for (int m = 0; m < 4; m++) begin
			for (int u = 0; u < 2; u++) begin
				if (m == 3 && u == 1) continue;
				configure(6'(m + 32 * u), TP_OFF, SYNC_SEL_SE, 1'(u), 1'b1, 1'b1);
				@(negedge ref_clk);
				check(16'(link.lane_on), 16'(((1 << (1 << m)) - 1) << (4 * u)));
			end
		end
		$display("lane map test done");
	endtask
	task automatic format_test;
		logic hit;
		// A reserved code must come out as normal data
		configure(6'h01, TP_RSVD, SYNC_SEL_SE, 1'b0, 1'b1, 1'b0);
		look(16'h0123, hit);
		check(16'(hit), 16'h0001);
		configure(6'h01, TP_OFF, SYNC_SEL_SE, 1'b0, 1'b0, 1'b0);
		look(16'h0923, hit);
		check(16'(hit), 16'h0001);
		configure(6'h01, TP_OFF, SYNC_SEL_SE, 1'b0, 1'b1, 1'b1);
		look(16'h0123, hit);
		check(16'(hit), 16'h0000);
		configure(6'h21, TP_OFF, SYNC_SEL_SE, 1'b0, 1'b1, 1'b0);
		look(16'h0123, hit);
		check(16'(hit), 16'h0000);
		$display("format test done");
	endtask
	task automatic pattern_test;
		logic [4:0]  codes [15] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08,
			5'h09, 5'h0a, 5'h0b, 5'h0d, 5'h0e, 5'h0f, 5'h10};
		logic [15:0] w0;
		logic [15:0] ch;
		foreach (codes[i]) begin
			configure(6'h01, codes[i], SYNC_SEL_SE, 1'b0, 1'b1, 1'b1);
			@(negedge ref_clk);
			w0 = link.lane_data[15:0];
			@(negedge ref_clk);
			ch = {7'h00, link.lane_k[0], link.lane_data[7:0]};
			case (codes[i])
				TP_LOW: check(16'(link.lane_hold_low), 16'h0001);
				TP_HIGH: check(16'(link.lane_hold_high), 16'h0001);
				TP_CLOCK: check(link.lane_data[15:0], CLOCK_WORD);
				TP_K28_5: check(ch, {8'h01, CH_K28_5});
				TP_K28_7: check(ch, {8'h01, CH_K28_7});
				TP_D21_5: check(ch, {8'h00, CH_D21_5});
				default: check(16'(w0 !== link.lane_data[15:0]), 16'h0001);
			endcase
		end
		$display("pattern test done");
	endtask
	task automatic sync_test;
		logic [1:0] sel;
		logic       hit;
		logic       rdy;
		int         n;
		for (int s = 0; s < 3; s++) begin
			sel = 2'(s);
			configure(6'h01, TP_OFF, sel, 1'b0, 1'b1, 1'b0);
			@(posedge ref_clk);
			rx_sync_request <= 1'b1;
			repeat (10) @(negedge ref_clk);
			check(16'(link_up), 16'(sel == SYNC_SEL_SW));
			n = 0;
			if (sel == SYNC_SEL_SE) begin
				// The link sits in sync, so nothing drains and the buffer must fill
				check({7'h00, link.lane_k[0], link.lane_data[7:0]}, {8'h01, CH_K28_5});
				@(posedge ref_clk);
				sample_valid <= 1'b1;
				sample_data <= 12'h001;
				// Ready is read before the edge that takes the push
				for (int i = 0; i < 12; i++) begin
					@(negedge ref_clk);
					if (sample_ready === 1'b1) n++;
					@(posedge ref_clk);
					sample_data <= 12'(n + 1);
				end
				check(16'(n), 16'(FIFO_DEPTH));
			end
			@(posedge ref_clk);
			rx_sync_request <= 1'b0;
			hit = 1'b0;
			for (int i = 0; i < 30 && n > 0; i++) begin
				@(negedge ref_clk);
				if (link.lane_data[15:0] === 16'h0001) hit = 1'b1;
				rdy = sample_ready;
				@(posedge ref_clk);
				if (rdy === 1'b1) sample_valid <= 1'b0;
			end
			if (n > 0) check(16'(hit), 16'h0001);
			repeat (10) @(negedge ref_clk);
			check(16'(link_up), 16'h0001);
			if (n > 0) check(16'(sample_ready), 16'h0001);
		end
		$display("sync test done");
	endtask
	initial begin
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (10) @(negedge ref_clk);
		check(16'(link.lane_on), 16'h0001);
		check(16'(link_up), 16'h0001);
		$display("reset test done");
		lane_map_test();
		format_test();
		pattern_test();
		sync_test();
		complete_run();
	end
endmodule
`default_nettype wire
